// file: srr_map.svh
// Register offsets, field positions, reset values and divider corrections
`ifndef SRR_MAP_SVH
`define SRR_MAP_SVH
`define SRR_ADDR_RATIO3 8'h06
`define SRR_ADDR_RATIO2 8'h07
`define SRR_ADDR_RATIO1 8'h08
`define SRR_ADDR_RATIO0 8'h09
`define SRR_ADDR_OUTCTL 8'h16
`define SRR_ADDR_RATCFG 8'h17
`define SRR_ADDR_STATUS 8'h18
`define SRR_OUTCTL_MAIN_TRI 0
`define SRR_OUTCTL_SEC_TRI 1
`define SRR_OUTCTL_SRC_LO 2
`define SRR_OUTCTL_STYLE 4
`define SRR_OUTCTL_PASS 5
`define SRR_RATCFG_SCALE_LO 0
`define SRR_RATCFG_DIV_LO 3
`define SRR_RATIO_RESET 32'h0000_0000
`define SRR_OUTCTL_RESET 8'h00
`define SRR_RATCFG_RESET 8'h00
`define SRR_DIV_SHIFT_00 2'h0
`define SRR_DIV_SHIFT_01 2'h1
`define SRR_DIV_SHIFT_10 2'h2
`define SRR_DIV_SHIFT_11 2'h0
`define SRR_SYNC_STAGES 2
`endif

// file: srr_pkg.sv
// Types shared by the ratio and output routing block
package srr_pkg;
   typedef enum logic [1:0]
   {
      SRR_SRC_REF = 2'h0,
      SRR_SRC_OFF = 2'h1,
      SRR_SRC_SYNTH = 2'h2,
      SRR_SRC_LOCK = 2'h3
   } srr_src_t;
   typedef enum logic [2:0]
   {
      SRR_X1, SRR_X2, SRR_X4, SRR_X8, SRR_D2, SRR_D4, SRR_D8, SRR_D16
   } srr_scale_t;
endpackage : srr_pkg

// file: srr_sync.sv
// Two flip-flop synchroniser for pin inputs
module srr_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_sys, // System clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic [WIDTH-1:0] async, // Asynchronous inputs
   output logic [WIDTH-1:0] sync // Synchronised outputs
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   initial
   begin
      if (WIDTH < 1) $error("srr_sync: WIDTH must be at least 1");
   end

   // Stage one feeds stage two and nothing else
   always_comb
   begin
      next_stage1 = async;
      next_sync = stage1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         stage1 <= '0;
         sync <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         sync <= next_sync;
      end
   end
endmodule : srr_sync

// file: srr_core.sv
// Ratio datapath and output gating of the clock synthesizer, glitch-free except secondary moves to or from the lock source
module srr_core
   import srr_pkg::*;
#(
   parameter int RATIO_W = 32, // 12.20 ratio width
   parameter int FRAC_W = 34 // Fractional-N word incl. divider correction
)
(
   input wire logic clk_sys, // System clock, 200 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic regWrite, // Register write strobe, one cycle
   input wire logic [7:0] regAddr, // Register byte address
   input wire logic [7:0] regWriteData, // Register write data
   output logic [7:0] regReadData, // Registered read data for regAddr
   input wire logic synthClock, // Synthesizer output clock pin
   input wire logic referenceClock, // Reference clock pin
   input wire logic pllLock, // PLL lock status pin
   output logic [FRAC_W-1:0] fracN, // Fractional-N value to synthesizer
   output logic fracUpdate, // Pulse when fracN inputs were written
   output logic mainOut, // Main synthesized clock pin level
   output logic mainOutEnable_n, // Main pin enable, low drives
   output logic secOut, // Secondary pin level
   output logic secOutEnable_n // Secondary pin enable, low drives
);
`include "srr_map.svh"

   initial
   begin
      if (RATIO_W != 32) $error("srr_core: RATIO_W must be 32");
      if (FRAC_W != RATIO_W + 2) $error("srr_core: FRAC_W must be RATIO_W+2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [2:0] pinSync;
   logic synthS;
   logic refS;
   logic lockS;
   srr_sync #(.WIDTH(3)) uSync
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .async({pllLock, referenceClock, synthClock}),
      .sync(pinSync)
   );
   assign synthS = pinSync[0];
   assign refS = pinSync[1];
   assign lockS = pinSync[2];

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic [RATIO_W-1:0] userRatio, next_userRatio;
   logic [7:0] outCtl, next_outCtl;
   logic [7:0] ratCfg, next_ratCfg;
   logic ratioValid, next_ratioValid;
   logic unlockHold, next_unlockHold;
   logic [RATIO_W-1:0] effRatio, next_effRatio;
   logic [FRAC_W-1:0] next_fracN;
   logic next_fracUpdate;
   logic [7:0] next_regReadData;
   logic mainRun, next_mainRun;
   logic next_mainOut, next_mainOutEnable_n;
   srr_src_t secSel, next_secSel;
   logic secRun, next_secRun;
   logic next_secOut, next_secOutEnable_n;
   logic lockView;
   logic fracWrite;
   logic [1:0] divShift;
   srr_scale_t scaleSel;
   srr_src_t wantSrc;
   logic wantSecRun;
   logic wantMainRun;
   logic srcLevel;

   assign scaleSel = srr_scale_t'(ratCfg[`SRR_RATCFG_SCALE_LO +: 3]);
   assign wantSrc = srr_src_t'(outCtl[`SRR_OUTCTL_SRC_LO +: 2]);
   assign lockView = lockS & ~unlockHold;
   assign fracWrite = regWrite & ((regAddr >= `SRR_ADDR_RATIO3 && regAddr <= `SRR_ADDR_RATIO0)
      || regAddr == `SRR_ADDR_RATCFG);

   ////////////////////////////////////////////////////////////////////////////
   // Register file and ratio datapath
   always_comb
   begin
      next_userRatio = userRatio;
      next_outCtl = outCtl;
      next_ratCfg = ratCfg;
      next_ratioValid = ratioValid;
      if (regWrite)
      begin
         // Byte 06 holds the integer MSBs, byte 09 the fraction LSBs
         case (regAddr)
            `SRR_ADDR_RATIO3: next_userRatio[31:24] = regWriteData;
            `SRR_ADDR_RATIO2: next_userRatio[23:16] = regWriteData;
            `SRR_ADDR_RATIO1: next_userRatio[15:8] = regWriteData;
            `SRR_ADDR_RATIO0:
            begin
               next_userRatio[7:0] = regWriteData;
               next_ratioValid = 1'b1;
            end
            `SRR_ADDR_OUTCTL: next_outCtl = regWriteData;
            `SRR_ADDR_RATCFG: next_ratCfg = regWriteData;
            default: next_ratioValid = ratioValid;
         endcase
      end
      // Shifts only; overflowed or shifted-out bits are dropped
      case (scaleSel)
         SRR_X1: next_effRatio = userRatio;
         SRR_X2: next_effRatio = userRatio << 1;
         SRR_X4: next_effRatio = userRatio << 2;
         SRR_X8: next_effRatio = userRatio << 3;
         SRR_D2: next_effRatio = userRatio >> 1;
         SRR_D4: next_effRatio = userRatio >> 2;
         SRR_D8: next_effRatio = userRatio >> 3;
         SRR_D16: next_effRatio = userRatio >> 4;
         default: next_effRatio = userRatio;
      endcase
      case (ratCfg[`SRR_RATCFG_DIV_LO +: 2])
         2'h0: divShift = `SRR_DIV_SHIFT_00;
         2'h1: divShift = `SRR_DIV_SHIFT_01;
         2'h2: divShift = `SRR_DIV_SHIFT_10;
         default: divShift = `SRR_DIV_SHIFT_11;
      endcase
      // Divider correction keeps the user ratio a plain out/in figure
      next_fracN = {2'h0, effRatio} << divShift;
      next_fracUpdate = fracWrite;
      // A new N throws the loop out of lock; hold it unlocked until the PLL agrees
      if (fracWrite)
         next_unlockHold = 1'b1;
      else if (!lockS)
         next_unlockHold = 1'b0;
      else
         next_unlockHold = unlockHold;
      case (regAddr)
         `SRR_ADDR_RATIO3: next_regReadData = userRatio[31:24];
         `SRR_ADDR_RATIO2: next_regReadData = userRatio[23:16];
         `SRR_ADDR_RATIO1: next_regReadData = userRatio[15:8];
         `SRR_ADDR_RATIO0: next_regReadData = userRatio[7:0];
         `SRR_ADDR_OUTCTL: next_regReadData = outCtl;
         `SRR_ADDR_RATCFG: next_regReadData = ratCfg;
         `SRR_ADDR_STATUS: next_regReadData = {5'h0, unlockHold, ratioValid, lockView};
         default: next_regReadData = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output gating; settings are applied only while output and source are low, except secondary moves to or from the lock source
   always_comb
   begin
      wantMainRun = ratioValid & ~outCtl[`SRR_OUTCTL_MAIN_TRI]
         & (lockView | outCtl[`SRR_OUTCTL_PASS]);
      next_mainRun = mainRun;
      next_mainOutEnable_n = mainOutEnable_n;
      if (!mainOut && !synthS)
      begin
         next_mainRun = wantMainRun;
         next_mainOutEnable_n = outCtl[`SRR_OUTCTL_MAIN_TRI];
      end
      next_mainOut = next_mainRun & synthS;
      wantSecRun = ratioValid & ~outCtl[`SRR_OUTCTL_SEC_TRI];
      next_secSel = secSel;
      next_secRun = secRun;
      next_secOutEnable_n = secOutEnable_n;
      case (wantSrc)
         SRR_SRC_REF: srcLevel = refS;
         SRR_SRC_SYNTH: srcLevel = synthS;
         default: srcLevel = 1'b0;
      endcase
      // Lock moves may cut a period short; clock moves wait for low levels
      if (wantSrc == SRR_SRC_LOCK || secSel == SRR_SRC_LOCK
         || (!secOut && !srcLevel))
      begin
         next_secSel = wantSrc;
         next_secRun = wantSecRun;
         next_secOutEnable_n = outCtl[`SRR_OUTCTL_SEC_TRI];
      end
      case (next_secSel)
         SRR_SRC_REF: next_secOut = next_secRun & refS;
         SRR_SRC_SYNTH: next_secOut = next_secRun & synthS;
         SRR_SRC_LOCK:
         begin
            // Style 0: push-pull, high when locked; style 1: open drain, low on unlock
            if (outCtl[`SRR_OUTCTL_STYLE])
            begin
               next_secOut = 1'b0;
               next_secOutEnable_n = outCtl[`SRR_OUTCTL_SEC_TRI] | lockView;
            end
            else
               next_secOut = next_secRun & lockView;
         end
         default: next_secOut = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         userRatio <= `SRR_RATIO_RESET;
         outCtl <= `SRR_OUTCTL_RESET;
         ratCfg <= `SRR_RATCFG_RESET;
         ratioValid <= 1'b0;
         unlockHold <= 1'b1;
         effRatio <= '0;
         fracN <= '0;
         fracUpdate <= 1'b0;
         regReadData <= 8'h00;
         mainRun <= 1'b0;
         mainOut <= 1'b0;
         mainOutEnable_n <= 1'b0;
         secSel <= SRR_SRC_REF;
         secRun <= 1'b0;
         secOut <= 1'b0;
         secOutEnable_n <= 1'b0;
      end
      else
      begin
         userRatio <= next_userRatio;
         outCtl <= next_outCtl;
         ratCfg <= next_ratCfg;
         ratioValid <= next_ratioValid;
         unlockHold <= next_unlockHold;
         effRatio <= next_effRatio;
         fracN <= next_fracN;
         fracUpdate <= next_fracUpdate;
         regReadData <= next_regReadData;
         mainRun <= next_mainRun;
         mainOut <= next_mainOut;
         mainOutEnable_n <= next_mainOutEnable_n;
         secSel <= next_secSel;
         secRun <= next_secRun;
         secOut <= next_secOut;
         secOutEnable_n <= next_secOutEnable_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_fracWr;
      fracWrite;
   endsequence
   sequence s_heldUnlocked;
      unlockHold && !lockView;
   endsequence
   property p_scaleUp;
      @(posedge clk_sys) disable iff (reset)
      (ratCfg[2] == 1'b0) |=> (effRatio == ($past(userRatio) << $past(ratCfg[1:0])));
   endproperty
   a_scaleUp: assert property (p_scaleUp) else $error("scale-up product wrong");
   property p_scaleDown;
      @(posedge clk_sys) disable iff (reset)
      (ratCfg[2:0] == 3'h7) |=> (effRatio == ($past(userRatio) >> 4));
   endproperty
   a_scaleDown: assert property (p_scaleDown) else $error("divide by 16 wrong");
   property p_fracN;
      @(posedge clk_sys) disable iff (reset)
      (ratCfg[4:3] == 2'h2) |=> (fracN == {$past(effRatio), 2'h0});
   endproperty
   a_fracN: assert property (p_fracN) else $error("divider correction wrong");
   property p_lossOfLock;
      @(posedge clk_sys) disable iff (reset)
      s_fracWr |=> s_heldUnlocked ##0 fracUpdate;
   endproperty
   a_lossOfLock: assert property (p_lossOfLock) else $error("write did not drop lock");
   property p_powerUpLow;
      @(posedge clk_sys) disable iff (reset)
      !ratioValid |=> !mainOut && !secOut ##1 (!mainOut || ratioValid);
   endproperty
   a_powerUpLow: assert property (p_powerUpLow) else $error("output before ratio");
   property p_unlockLow;
      @(posedge clk_sys) disable iff (reset)
      (!lockView && !outCtl[5] && !mainOut && $stable(lockView)) |=> !mainOut;
   endproperty
   a_unlockLow: assert property (p_unlockLow) else $error("clock out while unlocked");
   property p_mainRise;
      @(posedge clk_sys) disable iff (reset)
      $rose(mainOut) |-> $past(synthS) && mainRun;
   endproperty
   a_mainRise: assert property (p_mainRise) else $error("main pin runt edge");
   property p_tristate;
      @(posedge clk_sys) disable iff (reset)
      (outCtl[0] && !mainOut && !synthS) |=> mainOutEnable_n && !mainOut;
   endproperty
   a_tristate: assert property (p_tristate) else $error("main pin not released");
   property p_secRef;
      @(posedge clk_sys) disable iff (reset)
      (secSel == SRR_SRC_REF && secRun) ##1 (secSel == SRR_SRC_REF && secRun)
         |-> secOut == $past(refS);
   endproperty
   a_secRef: assert property (p_secRef) else $error("secondary not following ref");
endmodule : srr_core

// file: srr_core_test.sv
// Self-checking testbench of the synthesizer ratio and output routing core
`include "srr_map.svh"
module srr_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic regWrite = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWriteData = 8'h00;
   logic [7:0] regReadData;
   logic synthClock = 1'b0;
   logic referenceClock = 1'b0;
   logic pllLock = 1'b1;
   logic [33:0] fracN;
   logic fracUpdate, mainOut, mainOutEnable_n, secOut, secOutEnable_n;
   logic [3:0] divCnt = 4'h0;
   logic lastUpd;
   int errorCnt = 0;
   int nChecks = 0;
   int cycles = 0;
   //////////////////////////////////////////////////////////////////////////////
   // Clock, pin clocks at two distinct rates so the source mux is visible
   initial forever #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      divCnt <= divCnt + 4'h1;
      synthClock <= divCnt[1];
      referenceClock <= divCnt[2];
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errorCnt++;
         close_out();
      end
   end
   srr_core dut_u (.clk_sys(clk_sys), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
      .regWriteData(regWriteData), .regReadData(regReadData), .synthClock(synthClock),
      .referenceClock(referenceClock), .pllLock(pllLock), .fracN(fracN),
      .fracUpdate(fracUpdate), .mainOut(mainOut), .mainOutEnable_n(mainOutEnable_n),
      .secOut(secOut), .secOutEnable_n(secOutEnable_n));
   //////////////////////////////////////////////////////////////////////////////
   // Shared compare, verdict and bus tasks
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input string msg);
      nChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk
   task automatic close_out();
      if (errorCnt == 0 && nChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // Write strobe lasts one cycle; the update pulse stands only one cycle, so catch it then
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      #1 lastUpd = fracUpdate;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      repeat (2) @(posedge clk_sys);
      #1 d = regReadData;
   endtask : rd
   task automatic wr32(input logic [31:0] r);
      wr(`SRR_ADDR_RATIO3, r[31:24]);
      wr(`SRR_ADDR_RATIO2, r[23:16]);
      wr(`SRR_ADDR_RATIO1, r[15:8]);
      wr(`SRR_ADDR_RATIO0, r[7:0]);
   endtask : wr32
   // Lock is only seen again after the lock pin has been low once
   task automatic relock();
      @(posedge clk_sys);
      pllLock <= 1'b0;
      repeat (8) @(posedge clk_sys);
      pllLock <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask : relock
   task automatic watch(input bit sel, output int rises, output int highs);
      logic v;
      logic prev;
      rises = 0;
      highs = 0;
      prev = 1'b1;
      repeat (32)
      begin
         @(posedge clk_sys);
         #1 v = sel ? secOut : mainOut;
         if (v === 1'b1 && prev === 1'b0)
            rises++;
         if (v === 1'b1)
            highs++;
         prev = v;
      end
   endtask : watch
   //////////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped access, pins held low before a valid ratio
   task automatic t_reset();
      logic [7:0] d;
      int r;
      int h;
      for (int a = 6; a < 10; a++)
      begin
         rd(8'(a), d);
         chk(34'(d), 34'h0, "ratio reset");
      end
      rd(`SRR_ADDR_RATCFG, d);
      chk(34'(d), 34'h0, "scaler reset");
      rd(`SRR_ADDR_OUTCTL, d);
      chk(34'(d), 34'h0, "outctl reset");
      wr(8'h40, 8'h5a);
      rd(8'h40, d);
      chk(34'(d), 34'h0, "unmapped read");
      watch(1'b0, r, h);
      chk(34'(h), 34'h0, "main before ratio");
      watch(1'b1, r, h);
      chk(34'(h), 34'h0, "sec before ratio");
      chk(34'({mainOutEnable_n, secOutEnable_n}), 34'h0, "driven low");
   endtask : t_reset
   // Every scaler and divider code against a shift-based reference
   task automatic t_ratio();
      logic [31:0] ur;
      logic [31:0] eff;
      logic [7:0] d;
      // Top three and low four bits clear: no scaler code overflows or truncates
      ur = 32'h0345_6780;
      wr32(ur);
      chk(34'(lastUpd), 34'h1, "update pulse");
      for (int dv = 0; dv < 4; dv++)
         for (int s = 0; s < 8; s++)
         begin
            wr(`SRR_ADDR_RATCFG, {3'h0, 2'(dv), 3'(s)});
            chk(34'(lastUpd), 34'h1, "cfg update pulse");
            repeat (3) @(posedge clk_sys);
            #1 eff = (s < 4) ? ur << s : ur >> (s - 3);
            chk(fracN, {2'h0, eff} << ((dv == 3) ? 0 : dv), "fracN");
            chk(fracN, {2'h0, eff} << ((dv == 3) ? 0 : dv), "fracN div");
         end
      for (int a = 0; a < 4; a++)
      begin
         rd(8'(6 + a), d);
         chk(34'(d), 34'(ur[31 - 8 * a -: 8]), "ratio kept");
      end
      wr(`SRR_ADDR_RATCFG, 8'h00);
   endtask : t_ratio
   // Main pin: lock gating, pass when unlocked, tristate
   task automatic t_main();
      logic [7:0] d;
      int r;
      int h;
      relock();
      rd(`SRR_ADDR_STATUS, d);
      chk(34'(d[2:0]), 34'h3, "locked status");
      watch(1'b0, r, h);
      chk(34'(r >= 6), 34'h1, "main runs");
      wr(`SRR_ADDR_RATIO0, 8'h89);
      rd(`SRR_ADDR_STATUS, d);
      chk(34'(d[2:0]), 34'h6, "write unlocks");
      watch(1'b0, r, h);
      chk(34'(h), 34'h0, "main low unlocked");
      wr(`SRR_ADDR_OUTCTL, 8'h20);
      repeat (8) @(posedge clk_sys);
      watch(1'b0, r, h);
      chk(34'(r >= 6), 34'h1, "pass unlocked");
      wr(`SRR_ADDR_OUTCTL, 8'h21);
      repeat (10) @(posedge clk_sys);
      #1 chk(34'(mainOutEnable_n), 34'h1, "main tristate");
      wr(`SRR_ADDR_OUTCTL, 8'h00);
      relock();
   endtask : t_main
   // Secondary pin: every source code, lock styles, tristate
   task automatic t_sec();
      int r;
      int h;
      bit ok;
      for (int s = 0; s < 4; s++)
      begin
         wr(`SRR_ADDR_OUTCTL, {4'h0, 2'(s), 2'h0});
         repeat (10) @(posedge clk_sys);
         watch(1'b1, r, h);
         ok = (s == 0) ? (r >= 3 && r <= 5) : (s == 1) ? (h == 0) : (s == 2) ? (r >= 6) : (h == 32);
         chk(34'(ok), 34'h1, "sec source");
         chk(34'(ok), 34'h1, "sec source code");
      end
      wr(`SRR_ADDR_OUTCTL, 8'h1c);
      repeat (4) @(posedge clk_sys);
      #1 chk(34'({secOut, secOutEnable_n}), 34'h1, "open drain locked");
      wr(`SRR_ADDR_RATIO0, 8'h89);
      repeat (4) @(posedge clk_sys);
      #1 chk(34'({secOut, secOutEnable_n}), 34'h0, "open drain unlocked");
      wr(`SRR_ADDR_OUTCTL, 8'h0c);
      repeat (4) @(posedge clk_sys);
      #1 chk(34'({secOut, secOutEnable_n}), 34'h0, "push pull unlocked");
      wr(`SRR_ADDR_OUTCTL, 8'h2a);
      repeat (10) @(posedge clk_sys);
      #1 chk(34'(secOutEnable_n), 34'h1, "sec tristate");
   endtask : t_sec
   //////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_ratio();
      t_main();
      t_sec();
      close_out();
   end
endmodule : srr_core_test
